// file: fault_pkg.sv
// Package of register map, field layout and carrier types for the fault escalation unit
package fault_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_HARD_CAUSE = 12'h000;
  localparam logic [11:0] OFS_MEM_CAUSE = 12'h004;
  localparam logic [11:0] OFS_BUS_CAUSE = 12'h008;
  localparam logic [11:0] OFS_USAGE_CAUSE = 12'h00C;
  localparam logic [11:0] OFS_MEM_ADDR = 12'h010;
  localparam logic [11:0] OFS_BUS_ADDR = 12'h014;
  localparam logic [11:0] OFS_PRIORITY = 12'h018;
  localparam logic [11:0] OFS_ENABLES = 12'h01C;
  localparam logic [11:0] OFS_CORE_STATE = 12'h020;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HARD_VECTOR_BIT = 1;
  localparam int HARD_ESCALATED_BIT = 30;
  localparam int MEM_INSTR_BIT = 0;
  localparam int MEM_DATA_BIT = 1;
  localparam int MEM_POP_BIT = 3;
  localparam int MEM_PUSH_BIT = 4;
  localparam int MEM_ADDR_VALID_BIT = 7;
  localparam int BUS_PREFETCH_BIT = 0;
  localparam int BUS_PRECISE_BIT = 1;
  localparam int BUS_DEFERRED_BIT = 2;
  localparam int BUS_POP_BIT = 3;
  localparam int BUS_PUSH_BIT = 4;
  localparam int BUS_ADDR_VALID_BIT = 7;
  localparam int USE_UNKNOWN_BIT = 0;
  localparam int USE_BAD_STATE_BIT = 1;
  localparam int USE_BAD_RETURN_BIT = 2;
  localparam int USE_NO_COPROC_BIT = 3;
  localparam int USE_MISALIGN_BIT = 8;
  localparam int USE_ZERO_DIV_BIT = 9;
  localparam int PRI_MEM_LSB = 0;
  localparam int PRI_BUS_LSB = 8;
  localparam int PRI_USE_LSB = 16;
  localparam int EN_MEM_BIT = 0;
  localparam int EN_BUS_BIT = 1;
  localparam int EN_USE_BIT = 2;
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_LOCK_FROM_NMI_BIT = 1;
  localparam int ST_HARD_ACTIVE_BIT = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_CAUSE = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [23:0] RST_PRIORITY = 24'h00_0000;
  localparam logic [2:0] RST_ENABLES = 3'h0;

  // Exception numbers of the fixed and configurable classes
  localparam logic [3:0] EXC_NMI = 4'h2;
  localparam logic [3:0] EXC_HARD = 4'h3;
  localparam logic [3:0] EXC_MEM = 4'h4;
  localparam logic [3:0] EXC_BUS = 4'h5;
  localparam logic [3:0] EXC_USAGE = 4'h6;
  localparam logic [3:0] EXC_NONE = 4'h0;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic vector_read_err;
    logic instr_violation;
    logic instr_no_execute;
    logic data_violation;
    logic push_violation;
    logic pop_violation;
    logic push_bus_err;
    logic pop_bus_err;
    logic prefetch_bus_err;
    logic precise_bus_err;
    logic deferred_bus_err;
    logic no_coprocessor;
    logic unknown_opcode;
    logic bad_isa_state;
    logic bad_return_value;
    logic misaligned_access;
    logic zero_divisor;
    logic [31:0] addr;
  } fault_report_t;

  typedef struct packed {
    logic active;
    logic [3:0] exc_num;
    logic [7:0] priority_level;
  } core_context_t;

  typedef struct packed {
    logic valid;
    logic [3:0] exc_num;
  } fault_take_t;

endpackage

// file: fault_escalation_lockup.sv
// Fault classification, escalation and lockup unit with an AHB-Lite register slave
// How it works
// - Vector read bus error: hard fault, vector flag
// - Escalated configurable fault sets escalated flag
// - Fetch protection violation: mem fault, instruction flag
// - Load/store violation: mem fault, data flag
// - Push/pop violations: mem fault, separate flags
// - Push/pop bus errors: bus fault, separate flags
// - Prefetch bus error: bus fault, prefetch flag
// - Data bus error: precise or deferred flag
// - Coprocessor access: usage fault, no-coprocessor flag
// - Undefined opcode or bad state: usage flags
// - Bad return, misaligned, zero divide: own flags
// - No-execute fetch flags even without protection unit
// - Configurable priority and enable per fault class
// - Handler faulting same or lower priority escalates
// - Fault not above current priority escalates
// - Disabled handler fault escalates to hard fault
// - Bus fault pushing bus handler frame never escalates while bus fault enabled
// - Hard fault fixed priority below reset and NMI
// - Capture faulting address for data violations and precise bus errors only
// - Hard fault in NMI or hard handler locks up
// - Lockup holds until reset or NMI
// - Lockup from NMI handler released only by reset
// - Equal priority: lowest exception number first
`timescale 1ns/1ps
module fault_escalation_lockup #(
  parameter int PRIO_BITS = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire fault_pkg::fault_report_t report,
  input wire fault_pkg::core_context_t ctx,
  input wire logic nmi_request,
  output fault_pkg::fault_take_t take,
  output logic core_locked
);

  initial begin
    if (PRIO_BITS < 1 || PRIO_BITS > 8) begin
      $error("PRIO_BITS must lie in 1..8");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] hard_cause;
    logic [31:0] mem_cause;
    logic [31:0] bus_cause;
    logic [31:0] usage_cause;
    logic [31:0] mem_addr;
    logic [31:0] bus_addr;
    logic [23:0] prio;
    logic [2:0] enables;
    logic locked;
    logic lock_from_nmi;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    fault_pkg::fault_take_t take;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ****************************************
  // Combinational next state
  // ****************************************
  logic mem_ev;
  logic bus_ev;
  logic use_ev;
  logic [2:0] cls_ev;
  logic [2:0] cls_esc;
  logic [2:0] cls_take;
  logic vec_ev;
  logic hard_ev;
  logic [7:0] cur_pri;
  logic [7:0] cls_pri [3];
  logic [7:0] best_pri;
  logic [3:0] best_num;
  logic [31:0] clr;
  logic rd_ok;
  logic [11:0] a_ofs;
  logic in_nmi;
  logic in_hard;
  logic [7:0] pmask;

  always_comb begin
    st_nxt = st_r;
    pmask = 8'hFF << (8 - PRIO_BITS);
    mem_ev = report.instr_violation | report.instr_no_execute | report.data_violation
             | report.push_violation | report.pop_violation;
    bus_ev = report.push_bus_err | report.pop_bus_err | report.prefetch_bus_err
             | report.precise_bus_err | report.deferred_bus_err;
    use_ev = report.no_coprocessor | report.unknown_opcode | report.bad_isa_state
             | report.bad_return_value | report.misaligned_access | report.zero_divisor;
    cls_ev = {use_ev, bus_ev, mem_ev};
    vec_ev = report.vector_read_err;
    in_nmi = ctx.active && ctx.exc_num == fault_pkg::EXC_NMI;
    in_hard = ctx.active && ctx.exc_num == fault_pkg::EXC_HARD;
    // Thread mode has the lowest priority, so only disabled classes or classes at the lowest level escalate there
    cur_pri = ctx.active ? ctx.priority_level : 8'hFF;
    // Negative priorities of NMI and hard fault sit above every configurable class
    for (int i = 0; i < 3; i++) begin
      cls_pri[i] = st_r.prio[8*i +: 8] & pmask;
      cls_esc[i] = cls_ev[i] && (!st_r.enables[i]
                   || in_nmi || in_hard
                   || !(cls_pri[i] < (cur_pri & pmask)));
    end
    // Push of the bus handler's own frame keeps the bus fault unescalated
    if (report.push_bus_err && ctx.exc_num == fault_pkg::EXC_BUS && st_r.enables[1]) begin
      cls_esc[1] = 1'b0;
    end
    cls_take = cls_ev & ~cls_esc;
    hard_ev = vec_ev | (|cls_esc);

    // Sticky flags: set wins over a software clear in the same cycle
    clr = 32'h0000_0000;
    if (st_r.wr_pend) begin
      clr = hwdata;
      case (st_r.wr_addr)
        fault_pkg::OFS_HARD_CAUSE: st_nxt.hard_cause = st_r.hard_cause & ~clr;
        fault_pkg::OFS_MEM_CAUSE: st_nxt.mem_cause = st_r.mem_cause & ~clr;
        fault_pkg::OFS_BUS_CAUSE: st_nxt.bus_cause = st_r.bus_cause & ~clr;
        fault_pkg::OFS_USAGE_CAUSE: st_nxt.usage_cause = st_r.usage_cause & ~clr;
        fault_pkg::OFS_PRIORITY: st_nxt.prio = hwdata[23:0];
        fault_pkg::OFS_ENABLES: st_nxt.enables = hwdata[2:0];
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    if (!st_r.locked) begin
      st_nxt.hard_cause[fault_pkg::HARD_VECTOR_BIT] |= vec_ev;
      st_nxt.hard_cause[fault_pkg::HARD_ESCALATED_BIT] |= |cls_esc;
      st_nxt.mem_cause[fault_pkg::MEM_INSTR_BIT] |=
        report.instr_violation | report.instr_no_execute;
      st_nxt.mem_cause[fault_pkg::MEM_DATA_BIT] |= report.data_violation;
      st_nxt.mem_cause[fault_pkg::MEM_PUSH_BIT] |= report.push_violation;
      st_nxt.mem_cause[fault_pkg::MEM_POP_BIT] |= report.pop_violation;
      st_nxt.bus_cause[fault_pkg::BUS_PUSH_BIT] |= report.push_bus_err;
      st_nxt.bus_cause[fault_pkg::BUS_POP_BIT] |= report.pop_bus_err;
      st_nxt.bus_cause[fault_pkg::BUS_PREFETCH_BIT] |= report.prefetch_bus_err;
      st_nxt.bus_cause[fault_pkg::BUS_PRECISE_BIT] |= report.precise_bus_err;
      st_nxt.bus_cause[fault_pkg::BUS_DEFERRED_BIT] |= report.deferred_bus_err;
      st_nxt.usage_cause[fault_pkg::USE_NO_COPROC_BIT] |= report.no_coprocessor;
      st_nxt.usage_cause[fault_pkg::USE_UNKNOWN_BIT] |= report.unknown_opcode;
      st_nxt.usage_cause[fault_pkg::USE_BAD_STATE_BIT] |= report.bad_isa_state;
      st_nxt.usage_cause[fault_pkg::USE_BAD_RETURN_BIT] |= report.bad_return_value;
      st_nxt.usage_cause[fault_pkg::USE_MISALIGN_BIT] |= report.misaligned_access;
      st_nxt.usage_cause[fault_pkg::USE_ZERO_DIV_BIT] |= report.zero_divisor;
      // Only precise data faults carry a meaningful address
      if (report.data_violation) begin
        st_nxt.mem_addr = report.addr;
        st_nxt.mem_cause[fault_pkg::MEM_ADDR_VALID_BIT] = 1'b1;
      end
      if (report.precise_bus_err) begin
        st_nxt.bus_addr = report.addr;
        st_nxt.bus_cause[fault_pkg::BUS_ADDR_VALID_BIT] = 1'b1;
      end
    end

    // Handler selection: hard fault first, then lowest priority value, ties to lowest number
    best_pri = 8'hFF;
    best_num = fault_pkg::EXC_NONE;
    for (int i = 0; i < 3; i++) begin
      if (cls_take[i] && (best_num == fault_pkg::EXC_NONE || cls_pri[i] < best_pri)) begin
        best_pri = cls_pri[i];
        best_num = fault_pkg::EXC_MEM + 4'(i);
      end
    end
    st_nxt.take.valid = 1'b0;
    st_nxt.take.exc_num = fault_pkg::EXC_NONE;
    if (!st_r.locked) begin
      if (hard_ev && (in_nmi || in_hard)) begin
        st_nxt.locked = 1'b1;
        st_nxt.lock_from_nmi = in_nmi;
      end else if (hard_ev) begin
        st_nxt.take.valid = 1'b1;
        st_nxt.take.exc_num = fault_pkg::EXC_HARD;
      end else if (best_num != fault_pkg::EXC_NONE) begin
        st_nxt.take.valid = 1'b1;
        st_nxt.take.exc_num = best_num;
      end
    end else if (nmi_request && !st_r.lock_from_nmi) begin
      st_nxt.locked = 1'b0;
      st_nxt.take.valid = 1'b1;
      st_nxt.take.exc_num = fault_pkg::EXC_NMI;
    end

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    a_ofs = {haddr[11:2], 2'b00};
    rd_ok = hsel && hready && htrans[1] && !hwrite;
    st_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
    st_nxt.wr_addr = a_ofs;
    if (rd_ok) begin
      case (a_ofs)
        fault_pkg::OFS_HARD_CAUSE: st_nxt.rdata = st_r.hard_cause;
        fault_pkg::OFS_MEM_CAUSE: st_nxt.rdata = st_r.mem_cause;
        fault_pkg::OFS_BUS_CAUSE: st_nxt.rdata = st_r.bus_cause;
        fault_pkg::OFS_USAGE_CAUSE: st_nxt.rdata = st_r.usage_cause;
        fault_pkg::OFS_MEM_ADDR: st_nxt.rdata = st_r.mem_addr;
        fault_pkg::OFS_BUS_ADDR: st_nxt.rdata = st_r.bus_addr;
        fault_pkg::OFS_PRIORITY: st_nxt.rdata = {8'h00, st_r.prio};
        fault_pkg::OFS_ENABLES: st_nxt.rdata = {29'h0000_0000, st_r.enables};
        fault_pkg::OFS_CORE_STATE: st_nxt.rdata = {29'h0000_0000, in_hard,
                                                  st_r.lock_from_nmi, st_r.locked};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end else begin
      st_nxt.rdata = 32'h0000_0000;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{hard_cause: fault_pkg::RST_CAUSE, mem_cause: fault_pkg::RST_CAUSE,
                bus_cause: fault_pkg::RST_CAUSE, usage_cause: fault_pkg::RST_CAUSE,
                mem_addr: fault_pkg::RST_ADDR, bus_addr: fault_pkg::RST_ADDR,
                prio: fault_pkg::RST_PRIORITY, enables: fault_pkg::RST_ENABLES,
                locked: 1'b0, lock_from_nmi: 1'b0, wr_pend: 1'b0, wr_addr: 12'h000,
                rdata: 32'h0000_0000, take: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = st_r.take;
  assign core_locked = st_r.locked;

endmodule

// file: fault_source.sv
// Pipeline side model that reports fault causes for one cycle
`timescale 1ns/1ps
module fault_source (
  input wire logic core_clk,
  input wire logic fire,
  input wire logic [4:0] cause_sel,
  input wire logic [16:0] extra_mask,
  input wire logic [31:0] cause_addr,
  output fault_pkg::fault_report_t report
);
  logic [31:0] last_r;
  initial begin
    report = '0;
    last_r = 32'h0;
  end
  // Outside a report the address is inverted so a stale value can never match
  always @(posedge core_clk) begin
    report <= {17'h0_0000, ~last_r};
    if (fire) begin
      report <= {(17'h1_0000 >> cause_sel) | extra_mask, cause_addr};
      last_r <= cause_addr;
    end
  end
endmodule

// file: fault_escalation_lockup_assertions.sv
// Concurrent checks on the fault unit ports
`timescale 1ns/1ps
module fault_escalation_lockup_assertions #(
  parameter int PRIO_BITS = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire fault_pkg::fault_report_t report,
  input wire fault_pkg::core_context_t ctx,
  input wire logic nmi_request,
  input wire fault_pkg::fault_take_t take,
  input wire logic core_locked
);
  logic mem_f;
  logic use_f;
  logic one_f;
  logic thr;
  logic crit;
  logic lock_nmi_r;
  assign mem_f = |report[47:43];
  assign use_f = |report[37:32];
  assign one_f = $onehot(report[48:32]);
  assign thr = !ctx.active && !core_locked;
  // Any fault inside the NMI or hard fault handler is a hard fault
  assign crit = ctx.active && (ctx.exc_num inside {fault_pkg::EXC_NMI, fault_pkg::EXC_HARD});
  // Origin of lockup decides whether an NMI may release it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_nmi_r <= 1'b0;
    end else if (!core_locked && crit && (|report[48:32])) begin
      lock_nmi_r <= ctx.exc_num == fault_pkg::EXC_NMI;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  vector_take_a: assert property (
    report.vector_read_err && !crit && !core_locked |=> take == {1'b1, fault_pkg::EXC_HARD})
    else $error("vector error not taken as hard fault");
  mem_take_a: assert property (
    thr && mem_f && one_f |=> take.valid && take.exc_num inside {4'h4, 4'h3})
    else $error("memory fault not taken");
  usage_take_a: assert property (
    thr && use_f && one_f |=> take.valid && take.exc_num inside {4'h6, 4'h3})
    else $error("usage fault not taken");
  lock_entry_a: assert property (
    !core_locked && crit && (|report[48:32]) |=> core_locked && !take.valid)
    else $error("no lockup on fault in critical handler");
  locked_quiet_a: assert property (
    core_locked |-> !take.valid)
    else $error("exception taken while locked");
  lock_hold_a: assert property (
    core_locked && !nmi_request |=> core_locked)
    else $error("lockup left without NMI or reset");
  nmi_release_a: assert property (
    core_locked && nmi_request && !lock_nmi_r |=> !core_locked)
    else $error("NMI did not release lockup");
  nmi_lock_a: assert property (
    core_locked && lock_nmi_r |=> core_locked [*3])
    else $error("lockup from NMI handler released");
endmodule
bind fault_escalation_lockup fault_escalation_lockup_assertions #(.PRIO_BITS(PRIO_BITS)) chk_i (
  .core_clk(core_clk), .rstn(rstn), .report(report), .ctx(ctx), .nmi_request(nmi_request),
  .take(take), .core_locked(core_locked));

// file: tb.sv
// Self-checking bench for the fault escalation and lockup unit
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  fault_pkg::fault_report_t report;
  fault_pkg::core_context_t ctx = '0;
  fault_pkg::fault_take_t take;
  logic nmi_request = 1'b0;
  logic core_locked;
  logic fire = 1'b0;
  logic [4:0] cause_sel = 5'h00;
  logic [16:0] extra_mask = 17'h0_0000;
  logic [31:0] cause_addr = 32'h0;
  int err_count = 0;
  int check_count = 0;
  fault_escalation_lockup uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .report(report), .ctx(ctx),
    .nmi_request(nmi_request), .take(take), .core_locked(core_locked));
  fault_source src (.core_clk(core_clk), .fire(fire), .cause_sel(cause_sel),
    .extra_mask(extra_mask), .cause_addr(cause_addr), .report(report));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // Bounded wait; a bus that never answers ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk(32'h0, {31'h0, hresp});
  endtask
  task automatic clear_all();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 12'(c * 4), 32'hFFFF_FFFF);
    end
  endtask
  task automatic inject(input int i, input logic [4:0] exp_take, input logic exp_lock);
    @(posedge core_clk);
    cause_sel <= 5'(i);
    cause_addr <= 32'h2000_0100 | i;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({27'h0, exp_take}, {27'h0, take});
    chk({31'h0, exp_lock}, {31'h0, core_locked});
  endtask
  task automatic nmi_pulse(input logic exp_lock);
    @(posedge core_clk);
    nmi_request <= 1'b1;
    @(posedge core_clk);
    nmi_request <= 1'b0;
    #1;
    chk(exp_lock ? 32'h0 : 32'h12, {27'h0, take});
    chk({31'h0, exp_lock}, {31'h0, core_locked});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_regs();
    for (int a = 0; a < 10; a++) begin
      bus(1'b0, (a == 9) ? 12'h040 : 12'(a * 4), 32'h0);
      chk(32'h0, rd);
    end
    bus(1'b1, 12'h018, 32'h0030_2010);
    bus(1'b1, 12'h01C, 32'h0000_0007);
    bus(1'b1, 12'h040, 32'hFFFF_FFFF);
    bus(1'b0, 12'h018, 32'h0);
    chk(32'h0030_2010, rd);
    bus(1'b0, 12'h01C, 32'h0);
    chk(32'h0000_0007, rd);
    bus(1'b0, 12'h040, 32'h0);
    chk(32'h0, rd);
  endtask
  task automatic sc_classes();
    int cl;
    logic [31:0] exp;
    int bits [17] = '{1, 0, 0, 1, 4, 3, 4, 3, 0, 1, 2, 3, 0, 1, 2, 8, 9};
    for (int i = 0; i < 17; i++) begin
      cl = (i == 0) ? 0 : (i < 6) ? 1 : (i < 11) ? 2 : 3;
      exp = 32'h0000_0001 << bits[i];
      exp[7] = exp[7] | i == 3 | i == 9;
      inject(i, {1'b1, 4'(3 + cl)}, 1'b0);
      bus(1'b0, 12'(cl * 4), 32'h0);
      chk(exp, rd);
      if (i == 3 || i == 9) begin
        bus(1'b0, (i == 3) ? 12'h010 : 12'h014, 32'h0);
        chk(32'h2000_0100 | i, rd);
      end
      bus(1'b1, 12'(cl * 4), 32'hFFFF_FFFF);
      bus(1'b0, 12'(cl * 4), 32'h0);
      chk(32'h0, rd);
    end
  endtask
  // Disabled class, own kind, equal priority, higher priority, push error in bus handler
  task automatic sc_escalate();
    logic [31:0] en [5] = '{32'h3, 32'h7, 32'h7, 32'h7, 32'h7};
    logic [12:0] cx [5] = '{13'h0000, 13'h1630, 13'h1B20, 13'h1630, 13'h1520};
    int idx [5] = '{12, 12, 9, 1, 6};
    logic [4:0] tk [5] = '{5'h13, 5'h13, 5'h13, 5'h14, 5'h15};
    for (int j = 0; j < 5; j++) begin
      bus(1'b1, 12'h01C, en[j]);
      @(posedge core_clk);
      ctx <= cx[j];
      inject(idx[j], tk[j], 1'b0);
      bus(1'b0, 12'h000, 32'h0);
      chk((tk[j] == 5'h13) ? 32'h4000_0000 : 32'h0, rd);
      clear_all();
    end
  endtask
  // Equal priorities go to the lower number; a better priority or a hard fault wins
  task automatic sc_order();
    logic [31:0] pr [3] = '{32'h0030_2020, 32'h0030_1020, 32'h0030_2020};
    logic [16:0] mk [3] = '{17'h0_0100, 17'h0_0100, 17'h1_0000};
    int idx [3] = '{1, 1, 8};
    logic [4:0] tk [3] = '{5'h14, 5'h15, 5'h13};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 12'h018, pr[k]);
      @(posedge core_clk);
      ctx <= '0;
      extra_mask <= mk[k];
      inject(idx[k], tk[k], 1'b0);
      extra_mask <= 17'h0_0000;
      clear_all();
    end
  endtask
  task automatic sc_lockup();
    @(posedge core_clk);
    ctx <= 13'h1300;
    inject(12, 5'h00, 1'b1);
    clear_all();
    inject(13, 5'h00, 1'b1);
    bus(1'b0, 12'h00C, 32'h0);
    chk(32'h0, rd);
    bus(1'b0, 12'h020, 32'h0);
    chk(32'h1, rd & 32'h3);
    nmi_pulse(1'b0);
    @(posedge core_clk);
    ctx <= 13'h1200;
    inject(12, 5'h00, 1'b1);
    bus(1'b0, 12'h020, 32'h0);
    chk(32'h3, rd & 32'h3);
    nmi_pulse(1'b1);
    @(posedge core_clk);
    rstn <= 1'b0;
    ctx <= '0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    bus(1'b0, 12'h020, 32'h0);
    chk(32'h0, rd);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    sc_regs();
    sc_classes();
    sc_escalate();
    sc_order();
    sc_lockup();
    close_out();
  end
endmodule
